/* File: core/bus_condition_detect.sv */
// start and stop condition detector, toggling one flag per condition
`timescale 1ns/1ps
module bus_condition_detect (
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic nrst_in,
	output logic start_tog_out,
	output logic stop_tog_out
);
	logic start_q, start_d;
	logic stop_q, stop_d;

	// sda itself clocks these flops; scl must be steady high around the edge
	always_comb begin
		start_d = start_q ^ scl_in;
		stop_d = stop_q ^ scl_in;
	end

	always_ff @(negedge sda_in or negedge nrst_in) begin
		if (!nrst_in) begin
			start_q <= 1'b0;
		end else begin
			start_q <= start_d;
		end
	end

	always_ff @(posedge sda_in or negedge nrst_in) begin
		if (!nrst_in) begin
			stop_q <= 1'b0;
		end else begin
			stop_q <= stop_d;
		end
	end

	assign start_tog_out = start_q;
	assign stop_tog_out = stop_q;
endmodule

/* File: core/dual_eeprom_pkg.sv */
// constants, field positions and state types for the dual-port eeprom access logic
package dual_eeprom_pkg;

	// device address bytes seen on the display port
	localparam logic [7:0] DEV_MEM_WR = 8'hA0;
	localparam logic [7:0] DEV_MEM_RD = 8'hA1;
	localparam logic [7:0] DEV_SEG_WR = 8'h60;
	localparam logic [7:0] DEV_CFG_WR = 8'h62;
	localparam logic [7:0] DEV_CFG_RD = 8'h63;

	// memory organisation
	localparam int unsigned SEG_BYTES = 256;
	localparam int unsigned NUM_SEGMENTS = 4;
	localparam int unsigned MEM_BYTES = SEG_BYTES * NUM_SEGMENTS;
	localparam int unsigned PAGE_BYTES = 16;

	// port_bank_config: erased value and field positions
	localparam logic [7:0] CFG_RESET = 8'hFF;
	localparam int unsigned CFG_SINGLE_BANK_MODE_BIT = 0;
	localparam int unsigned CFG_BANK_OVERRIDE_VALUE_BIT = 1;
	localparam int unsigned CFG_BANK_OVERRIDE_ENABLE_BIT = 2;
	localparam int unsigned CFG_DDC_WRITE_ENABLE_BIT = 3;

	// bit slots within one byte frame
	localparam logic [3:0] LAST_DATA_BIT = 4'h7;
	localparam logic [3:0] ACK_BIT = 4'h8;

	// arbitration hold-off timeout
	localparam int unsigned CLK_FREQ_KHZ = 20000;
	localparam int unsigned ARB_TIMEOUT_MS = 1000;
	localparam int unsigned ARB_TIMEOUT_CYCLES = ARB_TIMEOUT_MS * CLK_FREQ_KHZ;

	typedef enum logic [9:0] {
		ST_IDLE    = 10'h001,
		ST_DEV     = 10'h002,
		ST_OFFSET  = 10'h004,
		ST_WDATA   = 10'h008,
		ST_RDATA   = 10'h010,
		ST_SEG     = 10'h020,
		ST_CFG_OFF = 10'h040,
		ST_CFG_WR  = 10'h080,
		ST_CFG_RD  = 10'h100,
		ST_WAIT    = 10'h200
	} slave_state_type;

	typedef enum logic [2:0] {
		ARB_IDLE = 3'h1,
		ARB_DSP  = 3'h2,
		ARB_DDC  = 3'h4
	} arb_state_type;

endpackage

/* File: core/dual_port_eeprom_access.sv */
// display-port access engine, configuration register and port arbitration
//
// How it works
// - no segment written: segment zero only
// - sequential reads wrap inside current segment
// - random read: A0, offset, restart, A1
// - master acks to continue, nack then stop
// - byte write: A0, offset, data, all acked
// - page write up to sixteen bytes acked
// - segment pointer reaches four 256-byte segments
// - write 60h with segment bits, then access
// - arbiter idle while both ports idle
// - start on one port holds other scl
// - release after initiator scl high one second
// - config bit0 selects one or two banks
// - config bit3 gates data-channel writes only
// - active bank from mode, override, pin
// - config byte at 62h write, 63h read
// - config write: 62h, dummy, value, acked
// - segment pointer volatile, write-only at 60h
// - config starts erased, all ones
// - master nack stops transmission until stop
`timescale 1ns/1ps
module dual_port_eeprom_access #(
	parameter int unsigned TIMEOUT_CYCLES = dual_eeprom_pkg::ARB_TIMEOUT_CYCLES
) (
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic DSP_SCL_IN,
	input wire logic DSP_SDA_IN,
	input wire logic DATACHANNEL_SERIAL_CLOCK_IN,
	input wire logic DDC_SDA_IN,
	input wire logic BANK_SELECT_PIN_IN,
	output logic DSP_SCL_OUT,
	output logic DSP_SCL_OE_OUT,
	output logic DSP_SDA_OUT,
	output logic DSP_SDA_OE_OUT,
	output logic DATACHANNEL_SERIAL_CLOCK_OUT,
	output logic DATACHANNEL_SERIAL_CLOCK_OE_OUT,
	output logic DDC_SDA_OUT,
	output logic DDC_SDA_OE_OUT,
	output logic DDC_UPPER_BANK_OUT,
	output logic DDC_WRITE_ALLOW_OUT
);
	import dual_eeprom_pkg::*;

	if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES > 32'h7FFFFFFF) begin : g_bad_timeout
		$error("TIMEOUT_CYCLES out of range");
	end

	function automatic logic is_tx_state(input slave_state_type st);
		is_tx_state = (st == ST_RDATA) || (st == ST_CFG_RD);
	endfunction

	// display-port link domain, clocked by its own scl
	logic [7:0] mem [0:MEM_BYTES-1];
	slave_state_type st_q, st_d;
	logic [3:0] bit_q, bit_d;
	logic [6:0] shift_q, shift_d;
	logic [7:0] offset_q, offset_d;
	logic [1:0] seg_q, seg_d;
	logic [7:0] cfg_q, cfg_d;
	logic cfg_tog_q, cfg_tog_d;
	logic ack_q, ack_d;
	logic start_seen_q, start_seen_d;
	logic stop_seen_q, stop_seen_d;
	logic sda_oe_q, sda_oe_d;
	logic mem_we;
	logic [9:0] mem_addr;
	logic [7:0] rx_byte, tx_byte;
	logic dsp_start_tog, dsp_stop_tog, ddc_start_tog;

	// system clock domain
	logic [1:0] cross_meta_q, cross_sync_q;
	logic cfg_tog_prev_q;
	logic [7:0] cfg_sys_q, cfg_sys_d;
	logic upper_q, upper_d, wr_allow_q, wr_allow_d;
	logic hold_dsp, hold_ddc;

	bus_condition_detect u_dsp_cond (
		.scl_in(DSP_SCL_IN),
		.sda_in(DSP_SDA_IN),
		.nrst_in(NRST_IN),
		.start_tog_out(dsp_start_tog),
		.stop_tog_out(dsp_stop_tog)
	);

	// the data-channel engine lives elsewhere; here only its starts matter
	bus_condition_detect u_ddc_cond (
		.scl_in(DATACHANNEL_SERIAL_CLOCK_IN),
		.sda_in(DDC_SDA_IN),
		.nrst_in(NRST_IN),
		.start_tog_out(ddc_start_tog),
		.stop_tog_out()
	);

	port_arbiter #(
		.TIMEOUT_CYCLES(TIMEOUT_CYCLES)
	) u_arb (
		.clk_in(CLK_IN),
		.nrst_in(NRST_IN),
		.dsp_scl_in(DSP_SCL_IN),
		.datachannel_serial_clock_in(DATACHANNEL_SERIAL_CLOCK_IN),
		.dsp_start_tog_in(dsp_start_tog),
		.ddc_start_tog_in(ddc_start_tog),
		.hold_dsp_out(hold_dsp),
		.hold_ddc_out(hold_ddc)
	);

	// receive side, evaluated at each rising scl
	// the start and stop toggles settle half an scl period before the
	// next rising edge, so they are read here without a synchroniser
	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		shift_d = shift_q;
		offset_d = offset_q;
		seg_d = seg_q;
		cfg_d = cfg_q;
		cfg_tog_d = cfg_tog_q;
		ack_d = ack_q;
		start_seen_d = start_seen_q;
		stop_seen_d = stop_seen_q;
		mem_we = 1'b0;
		rx_byte = {shift_q, DSP_SDA_IN};
		mem_addr = {seg_q, offset_q};
		if (dsp_start_tog != start_seen_q) begin
			// first rising edge after a start carries address bit 7
			start_seen_d = dsp_start_tog;
			st_d = ST_DEV;
			bit_d = 4'h1;
			shift_d = {6'h00, DSP_SDA_IN};
			ack_d = 1'b0;
			if (dsp_stop_tog != stop_seen_q) begin
				// a stop in between drops the volatile segment pointer
				stop_seen_d = dsp_stop_tog;
				seg_d = 2'h0;
			end
		end else if (st_q != ST_IDLE) begin
			bit_d = (bit_q == ACK_BIT) ? 4'h0 : bit_q + 4'h1;
			shift_d = rx_byte[6:0];
			if (bit_q == LAST_DATA_BIT) begin
				ack_d = 1'b1;
				case (st_q)
					ST_DEV: begin
						case (rx_byte)
							DEV_MEM_WR: st_d = ST_OFFSET;
							DEV_MEM_RD: st_d = ST_RDATA;
							DEV_SEG_WR: st_d = ST_SEG;
							DEV_CFG_WR: st_d = ST_CFG_OFF;
							DEV_CFG_RD: st_d = ST_CFG_RD;
							default: begin
								// includes 61h: the pointer cannot be read back
								st_d = ST_WAIT;
								ack_d = 1'b0;
							end
						endcase
					end
					ST_SEG: begin
						seg_d = rx_byte[1:0];
						st_d = ST_WAIT;
					end
					ST_OFFSET: begin
						offset_d = rx_byte;
						st_d = ST_WDATA;
					end
					ST_WDATA: begin
						mem_we = 1'b1;
						offset_d = {offset_q[7:4], offset_q[3:0] + 4'h1};
					end
					ST_CFG_OFF: begin
						// dummy offset, value ignored
						st_d = ST_CFG_WR;
					end
					ST_CFG_WR: begin
						cfg_d = rx_byte;
						cfg_tog_d = ~cfg_tog_q;
						st_d = ST_WAIT;
					end
					default: begin
						// transmitting or waiting for stop: no ack from us
						ack_d = 1'b0;
					end
				endcase
			end else if (bit_q == ACK_BIT) begin
				ack_d = 1'b0;
				if (is_tx_state(st_q) && !ack_q) begin
					if (DSP_SDA_IN) begin
						st_d = ST_WAIT;
					end else if (st_q == ST_RDATA) begin
						offset_d = offset_q + 8'h01;
					end
				end
			end
		end
	end

	always_ff @(posedge DSP_SCL_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			st_q <= ST_IDLE;
			bit_q <= 4'h0;
			shift_q <= 7'h00;
			offset_q <= 8'h00;
			seg_q <= 2'h0;
			cfg_q <= CFG_RESET;
			cfg_tog_q <= 1'b0;
			ack_q <= 1'b0;
			start_seen_q <= 1'b0;
			stop_seen_q <= 1'b0;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			offset_q <= offset_d;
			seg_q <= seg_d;
			cfg_q <= cfg_d;
			cfg_tog_q <= cfg_tog_d;
			ack_q <= ack_d;
			start_seen_q <= start_seen_d;
			stop_seen_q <= stop_seen_d;
		end
	end

	// array contents model the cells and are deliberately not reset
	always_ff @(posedge DSP_SCL_IN) begin
		if (mem_we) begin
			mem[mem_addr] <= rx_byte;
		end
	end

	// transmit side, sda changes only while scl is low
	always_comb begin
		tx_byte = (st_q == ST_CFG_RD) ? cfg_q : mem[{seg_q, offset_q}];
		sda_oe_d = 1'b0;
		if (bit_q == ACK_BIT) begin
			sda_oe_d = ack_q;
		end else if (is_tx_state(st_q)) begin
			sda_oe_d = ~tx_byte[3'(LAST_DATA_BIT - bit_q)];
		end
	end

	always_ff @(negedge DSP_SCL_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			sda_oe_q <= 1'b0;
		end else begin
			sda_oe_q <= sda_oe_d;
		end
	end

	// configuration crosses by toggle; cfg_q is stable for many scl
	// periods after each toggle, well beyond the synchroniser delay
	always_comb begin
		cfg_sys_d = cfg_sys_q;
		if (cross_sync_q[0] != cfg_tog_prev_q) begin
			cfg_sys_d = cfg_q;
		end
		if (cfg_sys_q[CFG_SINGLE_BANK_MODE_BIT]) begin
			upper_d = 1'b0;
		end else if (cfg_sys_q[CFG_BANK_OVERRIDE_ENABLE_BIT]) begin
			upper_d = cfg_sys_q[CFG_BANK_OVERRIDE_VALUE_BIT];
		end else begin
			upper_d = cross_sync_q[1];
		end
		// display-port writes never look at this bit
		wr_allow_d = cfg_sys_q[CFG_DDC_WRITE_ENABLE_BIT];
	end

	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			cross_meta_q <= 2'h0;
			cross_sync_q <= 2'h0;
			cfg_tog_prev_q <= 1'b0;
			cfg_sys_q <= CFG_RESET;
			upper_q <= 1'b0;
			wr_allow_q <= 1'b0;
		end else begin
			cross_meta_q <= {BANK_SELECT_PIN_IN, cfg_tog_q};
			cross_sync_q <= cross_meta_q;
			cfg_tog_prev_q <= cross_sync_q[0];
			cfg_sys_q <= cfg_sys_d;
			upper_q <= upper_d;
			wr_allow_q <= wr_allow_d;
		end
	end

	// open-drain pins only ever pull low
	assign DSP_SCL_OUT = 1'b0;
	assign DSP_SCL_OE_OUT = hold_dsp;
	assign DSP_SDA_OUT = 1'b0;
	assign DSP_SDA_OE_OUT = sda_oe_q;
	assign DATACHANNEL_SERIAL_CLOCK_OUT = 1'b0;
	assign DATACHANNEL_SERIAL_CLOCK_OE_OUT = hold_ddc;
	assign DDC_SDA_OUT = 1'b0;
	assign DDC_SDA_OE_OUT = 1'b0;
	assign DDC_UPPER_BANK_OUT = upper_q;
	assign DDC_WRITE_ALLOW_OUT = wr_allow_q;
endmodule

/* File: core/port_arbiter.sv */
// scl hold-off arbiter between the display port and the data-channel port
`timescale 1ns/1ps
module port_arbiter #(
	parameter int unsigned TIMEOUT_CYCLES = dual_eeprom_pkg::ARB_TIMEOUT_CYCLES
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic dsp_scl_in,
	input wire logic datachannel_serial_clock_in,
	input wire logic dsp_start_tog_in,
	input wire logic ddc_start_tog_in,
	output logic hold_dsp_out,
	output logic hold_ddc_out
);
	import dual_eeprom_pkg::*;

	localparam int unsigned CW = $clog2(TIMEOUT_CYCLES + 1);

	logic [3:0] meta_q, sync_q;
	logic [1:0] tog_prev_q;
	logic dsp_scl_s, datachannel_serial_clock_s, dsp_start, ddc_start, owner_scl;
	arb_state_type st_q, st_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic hold_dsp_q, hold_dsp_d, hold_ddc_q, hold_ddc_d;

	assign dsp_scl_s = sync_q[0];
	assign datachannel_serial_clock_s = sync_q[1];
	assign dsp_start = sync_q[2] ^ tog_prev_q[0];
	assign ddc_start = sync_q[3] ^ tog_prev_q[1];

	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		owner_scl = (st_q == ARB_DSP) ? dsp_scl_s : datachannel_serial_clock_s;
		case (st_q)
			ARB_IDLE: begin
				cnt_d = '0;
				// both lines high and no start: stay inactive
				if (dsp_start) begin
					st_d = ARB_DSP;
				end else if (ddc_start) begin
					st_d = ARB_DDC;
				end else begin
					st_d = ARB_IDLE;
				end
			end
			ARB_DSP, ARB_DDC: begin
				if (!owner_scl) begin
					cnt_d = '0;
				end else if (cnt_q == CW'(TIMEOUT_CYCLES - 1)) begin
					st_d = ARB_IDLE;
					cnt_d = '0;
				end else begin
					cnt_d = cnt_q + CW'(1);
				end
			end
			default: begin
				st_d = ARB_IDLE;
				cnt_d = '0;
			end
		endcase
		hold_ddc_d = (st_d == ARB_DSP);
		hold_dsp_d = (st_d == ARB_DDC);
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			meta_q <= 4'h0;
			sync_q <= 4'h0;
			tog_prev_q <= 2'h0;
			st_q <= ARB_IDLE;
			cnt_q <= '0;
			hold_dsp_q <= 1'b0;
			hold_ddc_q <= 1'b0;
		end else begin
			meta_q <= {ddc_start_tog_in, dsp_start_tog_in, datachannel_serial_clock_in, dsp_scl_in};
			sync_q <= meta_q;
			tog_prev_q <= sync_q[3:2];
			st_q <= st_d;
			cnt_q <= cnt_d;
			hold_dsp_q <= hold_dsp_d;
			hold_ddc_q <= hold_ddc_d;
		end
	end

	assign hold_dsp_out = hold_dsp_q;
	assign hold_ddc_out = hold_ddc_q;
endmodule

/* File: dv/bus_masters.sv */
// two-wire bus master models, index 0 the display port and 1 the data-channel port
`timescale 1ns/1ps
module bus_masters (
	input wire logic [1:0] scl_in,
	input wire logic [1:0] sda_in,
	output logic [1:0] scl_oe_out,
	output logic [1:0] sda_oe_out
);
	initial begin
		scl_oe_out = 2'h0;
		sda_oe_out = 2'h0;
	end
	// a held-off clock stays low, so wait until the line is really high
	task automatic rel(input int p);
		scl_oe_out[p] = 1'b0;
		while (!scl_in[p]) #10;
	endtask
	task automatic bit_io(input int p, input logic b, output logic r);
		scl_oe_out[p] = 1'b1;
		#40 sda_oe_out[p] = ~b;
		#40 rel(p);
		#40 r = sda_in[p];
		#40;
	endtask
	// clock only moves inside a frame; it stands high between frames
	task automatic start(input int p);
		scl_oe_out[p] = 1'b1;
		#40 sda_oe_out[p] = 1'b0;
		#40 rel(p);
		#80 sda_oe_out[p] = 1'b1;
		#80;
	endtask
	task automatic stop(input int p);
		scl_oe_out[p] = 1'b1;
		#40 sda_oe_out[p] = 1'b1;
		#40 rel(p);
		#80 sda_oe_out[p] = 1'b0;
		#80;
	endtask
	task automatic wr(input int p, input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(p, d[i], r);
		bit_io(p, 1'b1, r);
		ack = ~r;
	endtask
	// last set withholds the acknowledge and ends the read
	task automatic rd(input int p, input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(p, 1'b1, d[i]);
		bit_io(p, last, r);
	endtask
endmodule

/* File: dv/dual_port_eeprom_access_sva.sv */
// concurrent checks on the ports of the dual-port eeprom access block
`timescale 1ns/1ps
module dual_port_eeprom_access_sva #(
	parameter int unsigned TIMEOUT_CYCLES = 200
) (
	input wire logic CLK_IN,
	input wire logic NRST_IN,
	input wire logic DSP_SCL_IN,
	input wire logic DSP_SDA_IN,
	input wire logic DATACHANNEL_SERIAL_CLOCK_IN,
	input wire logic DDC_SDA_IN,
	input wire logic BANK_SELECT_PIN_IN,
	input wire logic DSP_SCL_OE_OUT,
	input wire logic DATACHANNEL_SERIAL_CLOCK_OE_OUT,
	input wire logic DDC_UPPER_BANK_OUT,
	input wire logic DDC_WRITE_ALLOW_OUT
);
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (!NRST_IN);
	logic [15:0] hi_cnt_q, hi_cnt_d;
	logic [5:0] pin_hist_q, pin_hist_d;
	logic sda_q;
	// raw high time of the display clock; a start also restarts it, since the hold begins there
	always_comb begin
		hi_cnt_d = hi_cnt_q;
		if (!DSP_SCL_IN || (sda_q && !DSP_SDA_IN)) begin
			hi_cnt_d = 16'h0;
		end else if (hi_cnt_q != 16'hFFFF) begin
			hi_cnt_d = hi_cnt_q + 16'h1;
		end
		pin_hist_d = {pin_hist_q[4:0], BANK_SELECT_PIN_IN};
	end
	always_ff @(posedge CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			hi_cnt_q <= 16'h0;
			pin_hist_q <= 6'h0;
			sda_q <= 1'b1;
		end else begin
			hi_cnt_q <= hi_cnt_d;
			pin_hist_q <= pin_hist_d;
			sda_q <= DSP_SDA_IN;
		end
	end
	a_hold_excl: assert property (!(DSP_SCL_OE_OUT && DATACHANNEL_SERIAL_CLOCK_OE_OUT))
		else $error("both clock lines held");
	a_dsp_grab: assert property ($fell(DSP_SDA_IN) && DSP_SCL_IN && $past(DSP_SCL_IN) && !DSP_SCL_OE_OUT
		&& !DATACHANNEL_SERIAL_CLOCK_OE_OUT |-> ##[1:8] DATACHANNEL_SERIAL_CLOCK_OE_OUT) else $error("display start did not hold data-channel clock");
	a_ddc_grab: assert property ($fell(DDC_SDA_IN) && DATACHANNEL_SERIAL_CLOCK_IN && $past(DATACHANNEL_SERIAL_CLOCK_IN) && !DSP_SCL_OE_OUT
		&& !DATACHANNEL_SERIAL_CLOCK_OE_OUT |-> ##[1:8] DSP_SCL_OE_OUT) else $error("data-channel start did not hold display clock");
	a_ddc_release: assert property (DATACHANNEL_SERIAL_CLOCK_OE_OUT |-> hi_cnt_q <= TIMEOUT_CYCLES + 8)
		else $error("hold kept past timeout");
	a_no_early: assert property ($fell(DATACHANNEL_SERIAL_CLOCK_OE_OUT) |-> hi_cnt_q >= TIMEOUT_CYCLES)
		else $error("hold released early");
	a_idle_quiet: assert property ((DSP_SCL_IN && DATACHANNEL_SERIAL_CLOCK_IN && DSP_SDA_IN && DDC_SDA_IN && !DSP_SCL_OE_OUT
		&& !DATACHANNEL_SERIAL_CLOCK_OE_OUT) [*8] |=> !DSP_SCL_OE_OUT && !DATACHANNEL_SERIAL_CLOCK_OE_OUT) else $error("arbiter woke while idle");
	a_cfg_owned: assert property ($changed(DDC_WRITE_ALLOW_OUT) |-> DATACHANNEL_SERIAL_CLOCK_OE_OUT || !$past(NRST_IN, 3))
		else $error("write allow moved without a display access");
	a_bank_cause: assert property ($changed(DDC_UPPER_BANK_OUT) |-> DATACHANNEL_SERIAL_CLOCK_OE_OUT || !$past(NRST_IN, 3)
		|| pin_hist_q != {6{pin_hist_q[0]}}) else $error("bank moved without cause");
endmodule

/* File: dv/tb_top.sv */
// self-checking testbench for the dual-port eeprom access block
`timescale 1ns/1ps
module tb_top;
	import dual_eeprom_pkg::*;
	localparam int unsigned TMO = 200;
	logic clk, nrst, pin, ack, d_scl_oe, d_sda_oe, c_scl_oe, c_sda_oe, upper, wallow;
	logic d_scl_o, d_sda_o, c_scl_o, c_sda_o;
	logic [1:0] m_scl, m_sda;
	wire logic d_scl, d_sda, c_scl, c_sda;
	logic [7:0] got;
	logic [7:0] buf_q [4];
	logic [11:0] tab [5] = '{12'hF14, 12'h087, 12'h081, 12'h062, 12'h044};
	int err_total = 0;
	int num_checks = 0;
	int cyc = 0;
	// pulled-up wires: the device side shows its output level only while its enable is high
	assign d_scl = ~m_scl[0] & (~d_scl_oe | d_scl_o);
	assign d_sda = ~m_sda[0] & (~d_sda_oe | d_sda_o);
	assign c_scl = ~m_scl[1] & (~c_scl_oe | c_scl_o);
	assign c_sda = ~m_sda[1] & (~c_sda_oe | c_sda_o);
	dual_port_eeprom_access #(.TIMEOUT_CYCLES(TMO)) dual_port_eeprom_access_i (.CLK_IN(clk), .NRST_IN(nrst),
		.DSP_SCL_IN(d_scl), .DSP_SDA_IN(d_sda), .DATACHANNEL_SERIAL_CLOCK_IN(c_scl), .DDC_SDA_IN(c_sda), .BANK_SELECT_PIN_IN(pin),
		.DSP_SCL_OUT(d_scl_o), .DSP_SCL_OE_OUT(d_scl_oe), .DSP_SDA_OUT(d_sda_o), .DSP_SDA_OE_OUT(d_sda_oe),
		.DATACHANNEL_SERIAL_CLOCK_OUT(c_scl_o), .DATACHANNEL_SERIAL_CLOCK_OE_OUT(c_scl_oe), .DDC_SDA_OUT(c_sda_o), .DDC_SDA_OE_OUT(c_sda_oe),
		.DDC_UPPER_BANK_OUT(upper), .DDC_WRITE_ALLOW_OUT(wallow));
	bus_masters m (.scl_in({c_scl, d_scl}), .sda_in({c_sda, d_sda}), .scl_oe_out(m_scl), .sda_oe_out(m_sda));
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic stop_test;
		if (err_total == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// a negative s skips the pointer write, so the pointer is back at zero after the last stop
	task automatic acc(input int s, input logic [7:0] off, input int n, input logic w);
		if (s >= 0) begin
			m.start(0);
			m.wr(0, DEV_SEG_WR, ack);
			chk(8'(ack), 8'h01);
			m.wr(0, 8'(s), ack);
			chk(8'(ack), 8'h01);
		end
		m.start(0);
		m.wr(0, DEV_MEM_WR, ack);
		chk(8'(c_scl_oe), 8'h01);
		m.wr(0, off, ack);
		chk(8'(ack), 8'h01);
		for (int i = 0; i < n; i++) begin
			if (w) begin
				m.wr(0, buf_q[i], ack);
				chk(8'(ack), 8'h01);
			end else begin
				if (i == 0) begin
					m.start(0);
					m.wr(0, DEV_MEM_RD, ack);
				end
				m.rd(0, i == n - 1, got);
				chk(got, buf_q[i]);
			end
		end
		m.stop(0);
	endtask
	task automatic cfg(input logic [7:0] v);
		m.start(0);
		m.wr(0, DEV_CFG_WR, ack);
		m.wr(0, 8'h00, ack);
		m.wr(0, v, ack);
		chk(8'(ack), 8'h01);
		m.stop(0);
	endtask
	// upper nibble is don't-care, so only the control bits are compared
	task automatic rdcfg(input logic [7:0] e);
		m.start(0);
		m.wr(0, DEV_CFG_RD, ack);
		m.rd(0, 1'b1, got);
		chk(got & 8'h0F, e & 8'h0F);
		// after the withheld acknowledge the line must stay released
		m.rd(0, 1'b1, got);
		chk(got, 8'hFF);
		m.stop(0);
	endtask
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 10000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		nrst = 1'b0;
		pin = 1'b0;
		repeat (10) @(posedge clk);
		#1 nrst = 1'b1;
		repeat (4) @(posedge clk);
		#1 chk({4'h0, upper, wallow, d_scl_oe, c_scl_oe}, 8'h04);
		chk({3'h0, c_sda_oe, d_scl_o, d_sda_o, c_scl_o, c_sda_o}, 8'h00);
		rdcfg(CFG_RESET);
		buf_q[0] = 8'h5A;
		acc(3, 8'hFF, 1, 1'b1);
		buf_q[0] = 8'hC3;
		acc(3, 8'h00, 1, 1'b1);
		buf_q[0] = 8'h11;
		acc(-1, 8'hFF, 1, 1'b1);
		buf_q = '{8'h01, 8'h02, 8'h03, 8'h04};
		acc(-1, 8'h0E, 4, 1'b1);
		buf_q[0] = 8'h5A;
		buf_q[1] = 8'hC3;
		acc(3, 8'hFF, 2, 1'b0);
		buf_q[0] = 8'h11;
		acc(-1, 8'hFF, 1, 1'b0);
		buf_q[0] = 8'h03;
		buf_q[1] = 8'h04;
		acc(-1, 8'h00, 2, 1'b0);
		m.start(0);
		m.wr(0, 8'h61, ack);
		m.stop(0);
		chk(8'(ack), 8'h00);
		for (int i = 0; i < 5; i++) begin
			cfg(tab[i][11:4]);
			@(posedge clk);
			#1 pin = tab[i][2];
			repeat (8) @(posedge clk);
			#1 chk({6'h0, upper, wallow}, {6'h0, tab[i][1:0]});
		end
		rdcfg(8'h04);
		repeat (TMO + 20) @(posedge clk);
		#1 chk(8'(c_scl_oe), 8'h00);
		m.start(1);
		repeat (8) @(posedge clk);
		#1 chk(8'(d_scl_oe), 8'h01);
		m.stop(1);
		repeat (TMO + 20) @(posedge clk);
		#1 chk(8'(d_scl_oe), 8'h00);
		stop_test();
	end
endmodule
bind dual_port_eeprom_access dual_port_eeprom_access_sva #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) sva_i (.CLK_IN(CLK_IN),
	.NRST_IN(NRST_IN), .DSP_SCL_IN(DSP_SCL_IN), .DSP_SDA_IN(DSP_SDA_IN), .DATACHANNEL_SERIAL_CLOCK_IN(DATACHANNEL_SERIAL_CLOCK_IN),
	.DDC_SDA_IN(DDC_SDA_IN), .BANK_SELECT_PIN_IN(BANK_SELECT_PIN_IN), .DSP_SCL_OE_OUT(DSP_SCL_OE_OUT),
	.DATACHANNEL_SERIAL_CLOCK_OE_OUT(DATACHANNEL_SERIAL_CLOCK_OE_OUT), .DDC_UPPER_BANK_OUT(DDC_UPPER_BANK_OUT), .DDC_WRITE_ALLOW_OUT(DDC_WRITE_ALLOW_OUT));
